// file: core/crl_pkg.sv
package crl_pkg;

	// Condition logic functions
	typedef enum logic [3:0]
	{
		CRL_OP_NONE,
		CRL_OP_AND,
		CRL_OP_OR,
		CRL_OP_XOR,
		CRL_OP_NAND,
		CRL_OP_NOR,
		CRL_OP_EQV,
		CRL_OP_ANDC,
		CRL_OP_ORC,
		CRL_OP_MOVE_FIELD,
		CRL_OP_SYSCALL,
		CRL_OP_RETURN
	} crl_op_type;

	// Instruction request from decode
	typedef struct packed
	{
		crl_op_type  op;
		logic [4:0]  dest_cond_bit;
		logic [4:0]  first_src_cond_bit;
		logic [4:0]  second_src_cond_bit;
		logic [2:0]  dest_cond_field;
		logic [2:0]  src_cond_field;
		logic        link_update_bit;
		logic [31:0] next_addr;
	} crl_req_type;

	localparam logic [31:0] CRL_CR_RESET        = 32'h0000_0000;
	localparam logic [31:0] CRL_LR_RESET        = 32'h0000_0000;
	localparam logic [31:0] CRL_MSR_RESET       = 32'h0000_0000;
	localparam logic [31:0] CRL_SRR_RESET       = 32'h0000_0000;
	localparam logic [31:0] CRL_SYSCALL_OFFSET  = 32'h0000_0c00;
	localparam logic [31:0] CRL_PREFIX_HIGH     = 32'hfff0_0000;
	localparam logic [31:0] CRL_PREFIX_LOW      = 32'h0000_0000;
	localparam logic [31:0] CRL_PRIV_OFFSET     = 32'h0000_0700;
	// Big-endian bit numbering: bit 0 is the msb
	localparam int          CRL_MSR_PR_BIT      = 17;
	localparam int          CRL_MSR_IP_BIT      = 25;
	localparam logic [31:0] CRL_MSR_LOW_MASK    = 32'h0000_ffff;
	localparam logic [31:0] CRL_LR_UNDEF        = 32'h0000_0000;
	localparam int          CRL_SYNC_CYCLES     = 2;

endpackage

// file: core/crl_unit.sv
`timescale 1ns/1ps
module crl_unit
(
	// Clock and reset
	input  wire logic            CLK,
	input  wire logic            RST,
	// Instruction request
	input  wire logic            REQ_VALID,
	input  wire crl_pkg::crl_req_type REQ,
	input  wire logic            PRIOR_DONE,
	output logic                 REQ_READY,
	// Architected state
	output logic [31:0]          COND_REG,
	output logic [31:0]          LINK_REG,
	output logic [31:0]          MSR_REG,
	output logic [31:0]          SAVE_RESTORE_0,
	output logic [31:0]          SAVE_RESTORE_1,
	// Fetch redirect and exceptions
	output logic                 REDIRECT,
	output logic [31:0]          REDIRECT_ADDR,
	output logic                 SYSCALL_EXC,
	output logic                 PRIV_EXC
);

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_SYNC
	} crl_state_type;

	crl_state_type    state_reg;
	crl_pkg::crl_req_type held_reg;
	logic [31:0]      cr_reg;
	logic [31:0]      lr_reg;
	logic [31:0]      msr_reg;
	logic [31:0]      save_restore_0_reg;
	logic [31:0]      save_restore_1_reg;
	logic             redirect_reg;
	logic [31:0]      redirect_addr_reg;
	logic             sc_exc_reg;
	logic             priv_exc_reg;

	// Big-endian bit index to vector index
	function automatic logic [4:0] crl_bitpos(input logic [4:0] idx);
		crl_bitpos = 5'h1f - idx;
	endfunction

	// Vector index of the lowest bit of a four-bit field
	function automatic logic [4:0] crl_field_lsb(input logic [2:0] fld);
		crl_field_lsb = 5'h1c - {fld, 2'b00};
	endfunction

	wire logic       accept    = REQ_VALID && (state_reg == ST_IDLE);
	wire logic       bit_a     = cr_reg[crl_bitpos(REQ.first_src_cond_bit)];
	wire logic       bit_b     = cr_reg[crl_bitpos(REQ.second_src_cond_bit)];
	wire logic [4:0] dest_pos  = crl_bitpos(REQ.dest_cond_bit);
	wire logic [4:0] src_lsb   = crl_field_lsb(REQ.src_cond_field);
	wire logic [3:0] src_field = cr_reg[src_lsb +: 4];
	wire logic [4:0] dst_lsb   = crl_field_lsb(REQ.dest_cond_field);
	wire logic       is_sync   = (REQ.op == crl_pkg::CRL_OP_SYSCALL) ||
	                             (REQ.op == crl_pkg::CRL_OP_RETURN);
	wire logic       is_cr_op  = !is_sync && (REQ.op != crl_pkg::CRL_OP_NONE);

	logic bit_result;
	always_comb
	begin
		case (REQ.op)
			crl_pkg::CRL_OP_AND:  bit_result = bit_a & bit_b;
			crl_pkg::CRL_OP_OR:   bit_result = bit_a | bit_b;
			crl_pkg::CRL_OP_XOR:  bit_result = bit_a ^ bit_b;
			crl_pkg::CRL_OP_NAND: bit_result = ~(bit_a & bit_b);
			crl_pkg::CRL_OP_NOR:  bit_result = ~(bit_a | bit_b);
			crl_pkg::CRL_OP_EQV:  bit_result = ~(bit_a ^ bit_b);
			crl_pkg::CRL_OP_ANDC: bit_result = bit_a & ~bit_b;
			crl_pkg::CRL_OP_ORC:  bit_result = bit_a | ~bit_b;
			default:              bit_result = 1'b0;
		endcase
	end

	logic [31:0] cr_next;
	always_comb
	begin
		cr_next = cr_reg;
		if (REQ.op == crl_pkg::CRL_OP_MOVE_FIELD)
			cr_next[dst_lsb +: 4] = src_field;
		else
			cr_next[dest_pos] = bit_result;
	end

	// Held op after prior instructions drain
	wire logic        user_mode = msr_reg[crl_bitpos(5'(crl_pkg::CRL_MSR_PR_BIT))];
	wire logic        new_ip    = msr_reg[crl_bitpos(5'(crl_pkg::CRL_MSR_IP_BIT))];
	wire logic [31:0] sc_vector = (new_ip ? crl_pkg::CRL_PREFIX_HIGH : crl_pkg::CRL_PREFIX_LOW)
	                              | crl_pkg::CRL_SYSCALL_OFFSET;
	wire logic [31:0] pr_vector = (new_ip ? crl_pkg::CRL_PREFIX_HIGH : crl_pkg::CRL_PREFIX_LOW)
	                              | crl_pkg::CRL_PRIV_OFFSET;
	wire logic        do_sync   = (state_reg == ST_SYNC) && PRIOR_DONE;
	wire logic        is_sc     = held_reg.op == crl_pkg::CRL_OP_SYSCALL;
	// Bits 16-31 in msb-first numbering are vector bits 15:0
	wire logic [31:0] msr_high  = msr_reg & crl_pkg::CRL_MSR_LOW_MASK;
	wire logic [31:0] save_restore_1_high = save_restore_1_reg & crl_pkg::CRL_MSR_LOW_MASK;
	wire logic [31:0] msr_keep  = msr_reg & ~crl_pkg::CRL_MSR_LOW_MASK;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state_reg         <= ST_IDLE;
			held_reg          <= '0;
			cr_reg            <= crl_pkg::CRL_CR_RESET;
			lr_reg            <= crl_pkg::CRL_LR_RESET;
			msr_reg           <= crl_pkg::CRL_MSR_RESET;
			save_restore_0_reg          <= crl_pkg::CRL_SRR_RESET;
			save_restore_1_reg          <= crl_pkg::CRL_SRR_RESET;
			redirect_reg      <= 1'b0;
			redirect_addr_reg <= 32'h0000_0000;
			sc_exc_reg        <= 1'b0;
			priv_exc_reg      <= 1'b0;
		end
		else
		begin
			redirect_reg <= 1'b0;
			sc_exc_reg   <= 1'b0;
			priv_exc_reg <= 1'b0;
			if (accept && is_cr_op)
			begin
				cr_reg <= cr_next;
				if (REQ.link_update_bit)
					lr_reg <= crl_pkg::CRL_LR_UNDEF;
			end
			if (accept && is_sync)
			begin
				held_reg  <= REQ;
				state_reg <= ST_SYNC;
			end
			if (do_sync)
			begin
				state_reg    <= ST_IDLE;
				redirect_reg <= 1'b1;
				if (is_sc)
				begin
					save_restore_0_reg          <= held_reg.next_addr;
					save_restore_1_reg          <= msr_high;
					sc_exc_reg        <= 1'b1;
					redirect_addr_reg <= sc_vector;
					if (held_reg.link_update_bit)
						lr_reg <= held_reg.next_addr;
				end
				else if (user_mode)
				begin
					priv_exc_reg      <= 1'b1;
					save_restore_0_reg          <= held_reg.next_addr - 32'h0000_0004;
					save_restore_1_reg          <= msr_high;
					redirect_addr_reg <= pr_vector;
				end
				else
				begin
					msr_reg           <= msr_keep | save_restore_1_high;
					redirect_addr_reg <= {save_restore_0_reg[31:2], 2'b00};
				end
			end
		end
	end

	// Ready while idle after the first clock out of reset; stalls during the synchronizing wait
	wire logic take_sync = accept && is_sync;
	wire logic sync_wait = (state_reg == ST_SYNC) && !PRIOR_DONE;
	wire logic ready_next = !take_sync && !sync_wait;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			REQ_READY <= 1'b0;
		else
			REQ_READY <= ready_next;
	end

	assign COND_REG       = cr_reg;
	assign LINK_REG       = lr_reg;
	assign MSR_REG        = msr_reg;
	assign SAVE_RESTORE_0 = save_restore_0_reg;
	assign SAVE_RESTORE_1 = save_restore_1_reg;
	assign REDIRECT       = redirect_reg;
	assign REDIRECT_ADDR  = redirect_addr_reg;
	assign SYSCALL_EXC    = sc_exc_reg;
	assign PRIV_EXC       = priv_exc_reg;

endmodule

// file: dv/crl_checker.sv
`timescale 1ns/1ps
module crl_checker
(
	input wire logic                 CLK, RST, REQ_VALID, PRIOR_DONE, REQ_READY,
	input wire logic                 REDIRECT, SYSCALL_EXC, PRIV_EXC,
	input wire crl_pkg::crl_req_type REQ,
	input wire logic [31:0]          COND_REG, LINK_REG, MSR_REG,
	input wire logic [31:0]          SAVE_RESTORE_0, SAVE_RESTORE_1, REDIRECT_ADDR
);
	logic        tk, a, b, x;
	logic [31:0] bm, bv, fm, sf, mv;
	assign tk = REQ_VALID && REQ_READY;
	assign a  = COND_REG[5'd31 - REQ.first_src_cond_bit];
	assign b  = COND_REG[5'd31 - REQ.second_src_cond_bit];
	assign bm = 32'h8000_0000 >> REQ.dest_cond_bit;
	assign bv = x ? (COND_REG | bm) : (COND_REG & ~bm);
	assign fm = 32'hf000_0000 >> {REQ.dest_cond_field, 2'b00};
	assign sf = (COND_REG << {REQ.src_cond_field, 2'b00}) & 32'hf000_0000;
	assign mv = (COND_REG & ~fm) | (sf >> {REQ.dest_cond_field, 2'b00});
	always_comb
	begin
		case (REQ.op)
			crl_pkg::CRL_OP_AND:  x = a & b;
			crl_pkg::CRL_OP_OR:   x = a | b;
			crl_pkg::CRL_OP_NAND: x = !(a & b);
			crl_pkg::CRL_OP_NOR:  x = !(a | b);
			crl_pkg::CRL_OP_EQV:  x = !(a ^ b);
			crl_pkg::CRL_OP_ANDC: x = a & !b;
			crl_pkg::CRL_OP_ORC:  x = a | !b;
			default:              x = a ^ b;
		endcase
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_sc; tk && REQ.op == crl_pkg::CRL_OP_SYSCALL && PRIOR_DONE ##1 PRIOR_DONE; endsequence
	sequence s_rt; tk && REQ.op == crl_pkg::CRL_OP_RETURN && PRIOR_DONE ##1 PRIOR_DONE; endsequence
	property p_basic; tk && REQ.op inside {crl_pkg::CRL_OP_AND, crl_pkg::CRL_OP_OR,
		crl_pkg::CRL_OP_XOR} |=> COND_REG == $past(bv); endproperty
	a_basic: assert property (p_basic) else $error("bit op wrong");
	property p_inv; tk && REQ.op inside {crl_pkg::CRL_OP_NAND, crl_pkg::CRL_OP_NOR,
		crl_pkg::CRL_OP_EQV} |=> COND_REG == $past(bv); endproperty
	a_inv: assert property (p_inv) else $error("inverted op wrong");
	property p_comp; tk && REQ.op inside {crl_pkg::CRL_OP_ANDC, crl_pkg::CRL_OP_ORC}
		|=> COND_REG == $past(bv); endproperty
	a_comp: assert property (p_comp) else $error("complement op wrong");
	property p_move; tk && REQ.op == crl_pkg::CRL_OP_MOVE_FIELD |=> COND_REG == $past(mv); endproperty
	a_move: assert property (p_move) else $error("field move wrong");
	property p_sc_red; s_sc |=> REDIRECT && SYSCALL_EXC && REDIRECT_ADDR == ((MSR_REG[6] ?
		crl_pkg::CRL_PREFIX_HIGH : crl_pkg::CRL_PREFIX_LOW) | crl_pkg::CRL_SYSCALL_OFFSET); endproperty
	a_sc_red: assert property (p_sc_red) else $error("call vector wrong");
	property p_sync; tk && REQ.op == crl_pkg::CRL_OP_SYSCALL ##1 !PRIOR_DONE |=> !REDIRECT; endproperty
	a_sync: assert property (p_sync) else $error("call did not wait");
	property p_sc_save; s_sc |=> SAVE_RESTORE_0 == $past(REQ.next_addr, 2) && SAVE_RESTORE_1[15:0]
		== MSR_REG[15:0] && (!$past(REQ.link_update_bit, 2) || LINK_REG == SAVE_RESTORE_0); endproperty
	a_sc_save: assert property (p_sc_save) else $error("call save wrong");
	property p_rfi; s_rt |=> REDIRECT && MSR_REG[15:0] == SAVE_RESTORE_1[15:0] &&
		REDIRECT_ADDR == {SAVE_RESTORE_0[31:2], 2'b00}; endproperty
	a_rfi: assert property (p_rfi) else $error("return wrong");
	property p_pulse; REDIRECT |=> !REDIRECT; endproperty
	a_pulse: assert property (p_pulse) else $error("redirect too long");
endmodule
bind crl_unit crl_checker u_chk (.*);

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic                 CLK = 0, RST = 1, REQ_VALID = 0, PRIOR_DONE = 1;
	crl_pkg::crl_req_type REQ = '0;
	logic                 REQ_READY, REDIRECT, SYSCALL_EXC, PRIV_EXC;
	logic [31:0]          COND_REG, LINK_REG, MSR_REG, SAVE_RESTORE_0, SAVE_RESTORE_1, REDIRECT_ADDR;
	logic [31:0]          cr = 0, machine_state_register = 0, s0 = 0, s1 = 0, e;
	integer               seed = 97, bad_count = 0, checked = 0, i, j, n, a, b;
	crl_unit u_dut (.*);
	always #12.5 CLK = ~CLK;
	task chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task complete_run;
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task cr_op(input crl_pkg::crl_op_type op);
		REQ = 58'({$random(seed), $random(seed)});
		REQ.op = op;
		REQ_VALID = 1;
		a = cr[31 - REQ.first_src_cond_bit];
		b = cr[31 - REQ.second_src_cond_bit];
		case (op)
			crl_pkg::CRL_OP_AND:  n = a & b;
			crl_pkg::CRL_OP_OR:   n = a | b;
			crl_pkg::CRL_OP_NAND: n = !(a & b);
			crl_pkg::CRL_OP_NOR:  n = !(a | b);
			crl_pkg::CRL_OP_EQV:  n = !(a ^ b);
			crl_pkg::CRL_OP_ANDC: n = a & !b;
			crl_pkg::CRL_OP_ORC:  n = a | !b;
			default:              n = a ^ b;
		endcase
		if (op == crl_pkg::CRL_OP_MOVE_FIELD)
			for (j = 0; j < 4; j++)
				cr[31 - 4 * REQ.dest_cond_field - j] = cr[31 - 4 * REQ.src_cond_field - j];
		else
			cr[31 - REQ.dest_cond_bit] = n[0];
		@(negedge CLK);
		chk(COND_REG, cr);
		chk(32'(REQ_READY), 32'h0000_0001);
		if (REQ.link_update_bit)
			chk(LINK_REG, crl_pkg::CRL_LR_UNDEF);
	endtask
	task sys(input crl_pkg::crl_op_type op, input logic slow);
		REQ = 58'({$random(seed), $random(seed)});
		REQ.op = op;
		REQ_VALID = 1;
		PRIOR_DONE = !slow;
		@(negedge CLK);
		REQ_VALID = 0;
		for (n = 0; n < 20 && REDIRECT !== 1'b1; n++)
		begin
			if (n == 3)
				PRIOR_DONE = 1;
			@(negedge CLK);
		end
		if (REDIRECT !== 1'b1)
		begin
			bad_count++;
			complete_run;
		end
		if (op == crl_pkg::CRL_OP_SYSCALL)
		begin
			s0 = REQ.next_addr;
			s1[15:0] = machine_state_register[15:0];
			e = (machine_state_register[6] ? crl_pkg::CRL_PREFIX_HIGH : crl_pkg::CRL_PREFIX_LOW) | crl_pkg::CRL_SYSCALL_OFFSET;
			if (REQ.link_update_bit)
				chk(LINK_REG, s0);
		end
		else
		begin
			machine_state_register[15:0] = s1[15:0];
			e = {s0[31:2], 2'b00};
		end
		chk(REDIRECT_ADDR, e);
		chk(32'(SYSCALL_EXC), 32'(op == crl_pkg::CRL_OP_SYSCALL));
		chk(32'(PRIV_EXC), 32'h0000_0000);
		chk(SAVE_RESTORE_0, s0);
		chk(SAVE_RESTORE_1 & 32'h0000_ffff, s1 & 32'h0000_ffff);
		chk(MSR_REG, machine_state_register);
	endtask
	initial
	begin
		repeat (6) @(negedge CLK);
		RST = 0;
		@(negedge CLK);
		for (i = 0; i < 300; i++)
			cr_op(crl_pkg::crl_op_type'(4'($unsigned($random(seed)) % 9 + 1)));
		for (i = 0; i < 8; i++)
		begin
			sys(crl_pkg::CRL_OP_SYSCALL, i[0]);
			sys(crl_pkg::CRL_OP_RETURN, i[1]);
		end
		RST = 1;
		@(negedge CLK);
		chk(COND_REG | LINK_REG | MSR_REG | SAVE_RESTORE_0 | SAVE_RESTORE_1, 32'h0);
		chk(32'({REQ_READY, REDIRECT, SYSCALL_EXC, PRIV_EXC}) | REDIRECT_ADDR, 32'h0);
		RST = 0;
		cr = 0;
		for (i = 0; i < 20; i++)
			cr_op(crl_pkg::crl_op_type'(4'($unsigned($random(seed)) % 9 + 1)));
		complete_run;
	end
endmodule
